// ==== verilog/scbd_top.v ====
// Overview of operation
// - Reset loads ROM limit and both RAM bounds with all ones.
// - ROM region always begins at address zero.
// - On overlap RAM select stays inactive; ROM select asserts unless bit 5 is set.
// - ROM select when address bits 19..12 not above ROM limit.
// - RAM select when address bits lie within both RAM bounds inclusive.
// - Bit 6 orders chain: one timer first, zero serial first; resets 0.
// - Bit 5 forces ROM select inactive high; resets to zero.
// - Bit 2 enables emulator mode reversing some bus directions; resets 0.
// - Bit 0 gives parallel port one pins to the timer unit.
// - Master, emulator off: drive writes, input reads, float on-chip reads.
// - Master, emulator on: drive on-chip reads and on-chip acknowledges outward.
// - Master, emulator off: float on-chip acknowledge, input off-chip acknowledge.
// - External master: float off-chip, writes, refresh; input reads; drive on-chip writes.
// - External master: drive on-chip acknowledge, input off-chip acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "scbd_consts.vh"
module scbd_top #(
    parameter AW = 8
) (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire clk_en_in,
    input wire [7:0] io_addr_in,
    input wire [7:0] io_wdata_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire [19:0] mem_addr_in,
    input wire mem_cycle_in,
    input wire [3:0] trans_in,
    input wire bus_master_in,
    input wire timer_chain_req_in,
    input wire serial_chain_req_in,
    input wire chain_enable_in,
    input wire [7:0] port_one_pins_in,
    input wire [7:0] timer_pins_in,
    input wire [7:0] port_one_dir_in,
    output reg [7:0] io_rdata_out,
    output reg io_rvalid_out,
    output reg rom_select_n_out,
    output reg ram_select_n_out,
    output reg [1:0] data_dir_out,
    output reg data_oe_n_out,
    output reg timer_chain_en_out,
    output reg serial_chain_en_out,
    output reg chain_enable_out,
    output reg [7:0] port_one_out,
    output reg [7:0] port_one_oe_n_out,
    output reg [7:0] timer_pins_out,
    output reg emulator_mode_flag_out,
    output reg [7:0] system_configuration_out
);
    // Boundary registers and configuration
    reg [AW-1:0] rom_limit_reg;
    reg [AW-1:0] ram_lower_bound_reg;
    reg [AW-1:0] ram_upper_bound_reg;
    reg [7:0] system_configuration;
    wire rom_hit;
    wire ram_hit;
    wire [1:0] dir_now;
    wire chain_order;
    wire emulator_mode_flag;
    wire timer_pins_mode;
    reg [7:0] next_rdata;
    reg next_rvalid;
    reg next_timer_en;
    reg next_serial_en;
    reg next_chain_out;

    assign chain_order = system_configuration[`SCBD_BIT_CHAIN_ORDER];
    assign emulator_mode_flag = system_configuration[`SCBD_BIT_EMULATOR];
    assign timer_pins_mode = system_configuration[`SCBD_BIT_TIMER_PINS];

    // Register writes; reserved bits are masked so they always read zero
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rom_limit_reg <= {AW{1'b1}};
            ram_lower_bound_reg <= {AW{1'b1}};
            ram_upper_bound_reg <= {AW{1'b1}};
            system_configuration <= `SCBD_CFG_RESET;
        end else if (clk_en_in && io_wr_in) begin
            case (io_addr_in)
                `SCBD_ADDR_ROM_LIMIT: rom_limit_reg <= io_wdata_in[AW-1:0];
                `SCBD_ADDR_RAM_LOWER: ram_lower_bound_reg <= io_wdata_in[AW-1:0];
                `SCBD_ADDR_RAM_UPPER: ram_upper_bound_reg <= io_wdata_in[AW-1:0];
                `SCBD_ADDR_SYS_CFG: system_configuration <= io_wdata_in & `SCBD_CFG_WMASK;
                default: system_configuration <= system_configuration;
            endcase
        end
    end

    // Read mux; unmapped ports give no valid strobe
    always @* begin
        next_rdata = 8'h00;
        next_rvalid = 1'b0;
        if (io_rd_in) begin
            next_rvalid = 1'b1;
            case (io_addr_in)
                `SCBD_ADDR_ROM_LIMIT: next_rdata = rom_limit_reg;
                `SCBD_ADDR_RAM_LOWER: next_rdata = ram_lower_bound_reg;
                `SCBD_ADDR_RAM_UPPER: next_rdata = ram_upper_bound_reg;
                `SCBD_ADDR_SYS_CFG: next_rdata = system_configuration;
                default: next_rvalid = 1'b0;
            endcase
        end
    end

    // Address decode into region hits
    scbd_decode #(
        .AW(AW)
    ) u_decode (
        .addr_field_in(mem_addr_in[`SCBD_ADDR_HI:`SCBD_ADDR_LO]),
        .mem_cycle_in(mem_cycle_in),
        .rom_limit_in(rom_limit_reg),
        .ram_low_in(ram_lower_bound_reg),
        .ram_high_in(ram_upper_bound_reg),
        .rom_disable_in(system_configuration[`SCBD_BIT_ROM_DISABLE]),
        .rom_hit_out(rom_hit),
        .ram_hit_out(ram_hit)
    );

    scbd_direction u_direction (
        .trans_in(trans_in),
        .bus_master_in(bus_master_in),
        .emulator_in(emulator_mode_flag),
        .dir_out(dir_now)
    );

    // Daisy chain: the first unit passes enable only when idle
    always @* begin
        if (chain_order) begin
            next_timer_en = chain_enable_in;
            next_serial_en = chain_enable_in && !timer_chain_req_in;
            next_chain_out = next_serial_en && !serial_chain_req_in;
        end else begin
            next_serial_en = chain_enable_in;
            next_timer_en = chain_enable_in && !serial_chain_req_in;
            next_chain_out = next_timer_en && !timer_chain_req_in;
        end
    end

    // Registered outputs, one cycle behind their inputs
    always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            io_rdata_out <= 8'h00;
            io_rvalid_out <= 1'b0;
            rom_select_n_out <= 1'b1;
            ram_select_n_out <= 1'b1;
            data_dir_out <= `SCBD_DIR_FLOAT;
            data_oe_n_out <= 1'b1;
            timer_chain_en_out <= 1'b0;
            serial_chain_en_out <= 1'b0;
            chain_enable_out <= 1'b0;
            port_one_out <= 8'h00;
            port_one_oe_n_out <= 8'hFF;
            timer_pins_out <= 8'h00;
            emulator_mode_flag_out <= 1'b0;
            system_configuration_out <= `SCBD_CFG_RESET;
        end else if (clk_en_in) begin
            io_rdata_out <= next_rdata;
            io_rvalid_out <= next_rvalid;
            // Selects are active low; high means inactive
            rom_select_n_out <= !rom_hit;
            ram_select_n_out <= !ram_hit;
            data_dir_out <= dir_now;
            data_oe_n_out <= (dir_now != `SCBD_DIR_OUT);
            timer_chain_en_out <= next_timer_en;
            serial_chain_en_out <= next_serial_en;
            chain_enable_out <= next_chain_out;
            emulator_mode_flag_out <= emulator_mode_flag;
            system_configuration_out <= system_configuration;
            if (timer_pins_mode) begin
                // Direction register is ignored in this mode
                timer_pins_out <= port_one_pins_in;
                port_one_out <= timer_pins_in;
                port_one_oe_n_out <= port_one_dir_in & 8'h00;
            end else begin
                timer_pins_out <= 8'h00;
                port_one_out <= 8'h00;
                port_one_oe_n_out <= 8'hFF;
            end
        end
    end
endmodule // scbd_top
`default_nettype wire

// ==== verilog/scbd_consts.vh ====
`ifndef SCBD_CONSTS_VH
`define SCBD_CONSTS_VH
// I/O port addresses of the configuration block
`define SCBD_ADDR_RAM_UPPER 8'hEA
`define SCBD_ADDR_RAM_LOWER 8'hEB
`define SCBD_ADDR_ROM_LIMIT 8'hEC
`define SCBD_ADDR_SYS_CFG 8'hED
// Reset values
`define SCBD_BOUND_RESET 8'hFF
`define SCBD_CFG_RESET 8'h00
// Configuration bit positions
`define SCBD_BIT_CHAIN_ORDER 6
`define SCBD_BIT_ROM_DISABLE 5
`define SCBD_BIT_EMULATOR 2
`define SCBD_BIT_TIMER_PINS 0
// Writable configuration bits; reserved bits read as zero
`define SCBD_CFG_WMASK 8'h65
// Address field compared against the boundary registers
`define SCBD_ADDR_HI 19
`define SCBD_ADDR_LO 12
// Transaction type codes
`define SCBD_TR_IDLE 4'h0
`define SCBD_TR_IO_WR_ON 4'h1
`define SCBD_TR_IO_RD_ON 4'h2
`define SCBD_TR_IO_WR_OFF 4'h3
`define SCBD_TR_IO_RD_OFF 4'h4
`define SCBD_TR_MEM_WR 4'h5
`define SCBD_TR_MEM_RD 4'h6
`define SCBD_TR_REFRESH 4'h7
`define SCBD_TR_ACK_ON 4'h8
`define SCBD_TR_ACK_OFF 4'h9
// Data bus direction codes
`define SCBD_DIR_FLOAT 2'h0
`define SCBD_DIR_IN 2'h1
`define SCBD_DIR_OUT 2'h2
`endif

// ==== verilog/scbd_decode.v ====
`timescale 1ns/1ps
`default_nettype none
`include "scbd_consts.vh"
module scbd_decode #(
    parameter AW = 8
) (
    input wire [AW-1:0] addr_field_in,
    input wire mem_cycle_in,
    input wire [AW-1:0] rom_limit_in,
    input wire [AW-1:0] ram_low_in,
    input wire [AW-1:0] ram_high_in,
    input wire rom_disable_in,
    output wire rom_hit_out,
    output wire ram_hit_out
);
    // Region compares; ROM starts at zero so only the top is checked
    wire rom_in_range;
    wire ram_in_range;
    assign rom_in_range = mem_cycle_in && (addr_field_in <= rom_limit_in);
    assign ram_in_range = mem_cycle_in && (addr_field_in >= ram_low_in) && (addr_field_in <= ram_high_in);
    assign rom_hit_out = rom_in_range && !rom_disable_in;
    assign ram_hit_out = ram_in_range && !rom_in_range;
endmodule // scbd_decode
`default_nettype wire

// ==== verilog/scbd_direction.v ====
`timescale 1ns/1ps
`default_nettype none
`include "scbd_consts.vh"
module scbd_direction (
    input wire [3:0] trans_in,
    input wire bus_master_in,
    input wire emulator_in,
    output reg [1:0] dir_out
);
    // Direction table for both mastership cases
    always @* begin
        dir_out = `SCBD_DIR_FLOAT;
        if (bus_master_in) begin
            case (trans_in)
                `SCBD_TR_IO_WR_ON, `SCBD_TR_IO_WR_OFF, `SCBD_TR_MEM_WR: dir_out = `SCBD_DIR_OUT;
                `SCBD_TR_IO_RD_OFF, `SCBD_TR_MEM_RD: dir_out = `SCBD_DIR_IN;
                `SCBD_TR_IO_RD_ON: dir_out = emulator_in ? `SCBD_DIR_OUT : `SCBD_DIR_FLOAT;
                `SCBD_TR_ACK_ON: dir_out = emulator_in ? `SCBD_DIR_OUT : `SCBD_DIR_FLOAT;
                `SCBD_TR_ACK_OFF: dir_out = `SCBD_DIR_IN;
                default: dir_out = `SCBD_DIR_FLOAT;
            endcase
        end else begin
            case (trans_in)
                `SCBD_TR_IO_RD_ON, `SCBD_TR_MEM_RD: dir_out = `SCBD_DIR_IN;
                `SCBD_TR_IO_WR_ON: dir_out = `SCBD_DIR_OUT;
                `SCBD_TR_ACK_ON: dir_out = `SCBD_DIR_OUT;
                `SCBD_TR_ACK_OFF: dir_out = `SCBD_DIR_IN;
                default: dir_out = `SCBD_DIR_FLOAT;
            endcase
        end
    end
endmodule // scbd_direction
`default_nettype wire

// ==== sim/scbd_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scbd_consts.vh"
module scbd_far_side (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic own_in,
    input wire logic [3:0] trans_cmd_in,
    output logic master_out,
    output logic [3:0] trans_out
);
    // External master hands the cycle type over one clock late, as a slow agent would
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            master_out <= 1'b1;
            trans_out <= `SCBD_TR_IDLE;
        end else begin
            master_out <= own_in;
            trans_out <= trans_cmd_in;
        end
    end
endmodule // scbd_far_side
`default_nettype wire

// ==== sim/scbd_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scbd_consts.vh"
module scbd_props (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic [7:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic io_wr_in,
    input wire logic [19:0] mem_addr_in,
    input wire logic mem_cycle_in,
    input wire logic [3:0] trans_in,
    input wire logic bus_master_in,
    input wire logic rom_select_n_out,
    input wire logic ram_select_n_out,
    input wire logic [1:0] data_dir_out,
    input wire logic data_oe_n_out,
    input wire logic emulator_mode_flag_out,
    input wire logic [7:0] system_configuration_out
);
    logic [7:0] lim;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] cfg;
    wire logic [7:0] pg = mem_addr_in[19:12];
    // Shadow copies of the bounds and configuration, so decode can be judged without peeking inside
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lim <= 8'hFF;
            lo <= 8'hFF;
            hi <= 8'hFF;
            cfg <= `SCBD_CFG_RESET;
        end else if (clk_en_in && io_wr_in) begin
            // Config shadow: the copy on the outputs lags one clock behind the decode
            if (io_addr_in == `SCBD_ADDR_SYS_CFG) cfg <= io_wdata_in & `SCBD_CFG_WMASK;
            if (io_addr_in == `SCBD_ADDR_ROM_LIMIT) lim <= io_wdata_in;
            if (io_addr_in == `SCBD_ADDR_RAM_LOWER) lo <= io_wdata_in;
            if (io_addr_in == `SCBD_ADDR_RAM_UPPER) hi <= io_wdata_in;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rom_hit;
        clk_en_in && mem_cycle_in && pg <= lim;
    endsequence
    sequence s_ram_hit;
        clk_en_in && mem_cycle_in && pg >= lo && pg <= hi;
    endsequence
    AST_ROM_HIT: assert property (s_rom_hit ##0 !cfg[5] |=> !rom_select_n_out)
        else $error("rom select missing");
    AST_ROM_OFF: assert property (clk_en_in && cfg[5] |=> rom_select_n_out)
        else $error("rom select not disabled");
    AST_OVERLAP: assert property (s_rom_hit ##0 s_ram_hit |=> ram_select_n_out)
        else $error("ram select during overlap");
    AST_RAM_HIT: assert property (s_ram_hit ##0 pg > lim |=> !ram_select_n_out)
        else $error("ram select missing");
    AST_DIR_MASTER: assert property (clk_en_in && bus_master_in && !cfg[2]
        && (trans_in == 4'h2 || trans_in == 4'h8) |=> data_dir_out == 2'h0) else $error("bus not floated");
    AST_DIR_EMU: assert property (clk_en_in && bus_master_in && cfg[2]
        && trans_in == 4'h2 |=> data_dir_out == 2'h2) else $error("emulator read not driven");
    AST_DIR_EXT: assert property (clk_en_in && !bus_master_in && trans_in == 4'h8 |=> data_dir_out == 2'h2)
        else $error("ack not driven for external master");
    AST_OE: assert property (data_oe_n_out == (data_dir_out != 2'h2))
        else $error("enable disagrees with direction");
    AST_EMU_FLAG: assert property (emulator_mode_flag_out == system_configuration_out[2])
        else $error("emulator flag mismatch");
endmodule // scbd_props
bind scbd_top scbd_props scbd_props_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .mem_addr_in(mem_addr_in),
    .mem_cycle_in(mem_cycle_in), .trans_in(trans_in), .bus_master_in(bus_master_in),
    .rom_select_n_out(rom_select_n_out), .ram_select_n_out(ram_select_n_out), .data_dir_out(data_dir_out),
    .data_oe_n_out(data_oe_n_out), .emulator_mode_flag_out(emulator_mode_flag_out),
    .system_configuration_out(system_configuration_out));
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_in, rstn_in, io_wr, io_rd, mcyc, own, ci, tq, sq, bm, rv, rs_n, ms_n, te, se, ceo;
    logic [7:0] ia, wd, tp, rdat, p1, p1oe;
    logic [19:0] ma;
    logic [3:0] tc, tr;
    logic [1:0] dir;
    int n_mismatch = 0;
    int n_tests = 0;
    scbd_far_side scbd_far_side_i (.clk_in(clk_sys_in), .rstn_in(rstn_in), .own_in(own), .trans_cmd_in(tc),
        .master_out(bm), .trans_out(tr));
    scbd_top scbd_top_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_en_in(1'b1), .io_addr_in(ia),
        .io_wdata_in(wd), .io_wr_in(io_wr), .io_rd_in(io_rd), .mem_addr_in(ma), .mem_cycle_in(mcyc),
        .trans_in(tr), .bus_master_in(bm), .timer_chain_req_in(tq), .serial_chain_req_in(sq),
        .chain_enable_in(ci), .port_one_pins_in(8'h00), .timer_pins_in(tp), .port_one_dir_in(8'hFF),
        .io_rdata_out(rdat), .io_rvalid_out(rv), .rom_select_n_out(rs_n), .ram_select_n_out(ms_n),
        .data_dir_out(dir), .data_oe_n_out(), .timer_chain_en_out(te), .serial_chain_en_out(se),
        .chain_enable_out(ceo), .port_one_out(p1), .port_one_oe_n_out(p1oe), .timer_pins_out(),
        .emulator_mode_flag_out(), .system_configuration_out());
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        ia <= a;
        wd <= d;
        io_wr <= 1'b1;
        @(posedge clk_sys_in);
        io_wr <= 1'b0;
    endtask
    // Read answer is registered on the same clock that takes the request
    task rd(input logic [7:0] a, input logic v, input logic [7:0] d);
        @(posedge clk_sys_in);
        ia <= a;
        io_rd <= 1'b1;
        @(posedge clk_sys_in);
        io_rd <= 1'b0;
        #1 chk({7'h00, rv}, {7'h00, v});
        chk(rdat, d);
    endtask
    task mem(input logic [19:0] a, input logic r, input logic m);
        @(posedge clk_sys_in);
        ma <= a;
        mcyc <= 1'b1;
        @(posedge clk_sys_in);
        #1 chk({6'h00, rs_n, ms_n}, {6'h00, r, m});
    endtask
    // Far side adds one clock, the registered direction output another
    task bus(input logic o, input logic [3:0] t, input logic [1:0] d);
        @(posedge clk_sys_in);
        own <= o;
        tc <= t;
        repeat (2) @(posedge clk_sys_in);
        #1 chk({6'h00, dir}, {6'h00, d});
    endtask
    task chain(input logic [2:0] q, input logic [2:0] x);
        @(posedge clk_sys_in);
        {ci, tq, sq} <= q;
        @(posedge clk_sys_in);
        #1 chk({5'h00, te, se, ceo}, {5'h00, x});
    endtask
    function logic [1:0] xd(input logic o, input logic e, input logic [3:0] t);
        if (o) begin
            case (t)
                4'h1, 4'h3, 4'h5: xd = 2'h2;
                4'h4, 4'h6, 4'h9: xd = 2'h1;
                4'h2, 4'h8: xd = e ? 2'h2 : 2'h0;
                default: xd = 2'h0;
            endcase
        end else begin
            case (t)
                4'h2, 4'h6, 4'h9: xd = 2'h1;
                4'h1, 4'h8: xd = 2'h2;
                default: xd = 2'h0;
            endcase
        end
    endfunction
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Guard against a hung run
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_mismatch++;
        complete_run;
    end
    initial begin
        {rstn_in, io_wr, io_rd, mcyc, ci, tq, sq, ia, wd, ma, tc} = '0;
        own = 1'b1;
        tp = 8'hA5;
        repeat (5) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rd(8'hEA, 1'b1, 8'hFF);
        rd(8'hEB, 1'b1, 8'hFF);
        rd(8'hEC, 1'b1, 8'hFF);
        rd(8'hED, 1'b1, 8'h00);
        rd(8'hE0, 1'b0, 8'h00);
        mem(20'hF_F000, 1'b0, 1'b1);
        wr(8'hEC, 8'h0F);
        wr(8'hEB, 8'h10);
        wr(8'hEA, 8'h20);
        mem(20'h0_0000, 1'b0, 1'b1);
        mem(20'h0_F123, 1'b0, 1'b1);
        mem(20'h1_0000, 1'b1, 1'b0);
        mem(20'h2_0FFF, 1'b1, 1'b0);
        mem(20'h2_1000, 1'b1, 1'b1);
        wr(8'hEB, 8'h08);
        mem(20'h0_8000, 1'b0, 1'b1);
        chain(3'b101, 3'b010);
        chain(3'b110, 3'b110);
        wr(8'hED, 8'hFF);
        rd(8'hED, 1'b1, 8'h65);
        mem(20'h0_0000, 1'b1, 1'b1);
        chk(p1, 8'hA5);
        chk(p1oe, 8'h00);
        chain(3'b110, 3'b100);
        chain(3'b101, 3'b110);
        chain(3'b100, 3'b111);
        chain(3'b011, 3'b000);
        for (int e = 0; e < 2; e++) begin
            wr(8'hED, e[0] ? 8'h04 : 8'h00);
            for (int o = 0; o < 2; o++)
                for (int t = 0; t < 10; t++)
                    bus(o[0], t[3:0], xd(o[0], e[0], t[3:0]));
        end
        complete_run;
    end
endmodule // tb
`default_nettype wire
